// ===== design/exec_cfg.svh
// Constants for the branch, system-register and special-store execution unit.
// Assumes inclusion by the package and by the testbench files.
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define OP_JUMP_VIA_REGISTER       5'h13
`define OP_JUMP_LINK_VIA_REGISTER       5'h14
`define OP_JUMP_PC_RELATIVE       5'h15
`define OP_JUMP_LINK_PC_RELATIVE       5'h16
`define OP_GET_A      5'h19
`define OP_GET_B      5'h1A
`define OP_PUT        5'h1B
`define OP_ADDSUBI    5'h1C
`define OP_THREAD     5'h1D
`define OP_STORE      5'h1E
`define LINK_REG      3'h7
`define PC_STEP       16'h0002
`define CARRY_FLAG    3'h6
`define CARRY_HI_FLAG 3'h7
`define DATA_BASE     16'h8000
`define EXC_UNALIGNED 5'h02
`define EXC_BADADDR   5'h04
`define EXC_ILLEGAL   5'h01
`endif

// ===== design/exec_pkg.sv
// Types shared by the execution unit and its state register.
// Assumes the constants header in the same folder.
`include "exec_cfg.svh"
package exec_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DONE = 2'b01
    } phase_type;

    typedef struct packed {
        logic [15:0] pc;
        logic        pc_load;
        logic        exc;
        logic [4:0]  exc_bits;
        logic [15:0] rd_data;
        logic [2:0]  rd_idx;
        logic        rd_we;
        logic [15:0] ra_data;
        logic [2:0]  ra_idx;
        logic        ra_we;
        logic [7:0]  flags;
        logic        flags_we;
        logic [15:0] ret_addr;
        logic [15:0] fault_addr;
        logic [4:0]  cause;
        logic        zero_en;
        logic        irq_mask;
        logic        irq_block;
        logic        mem_we;
        logic [15:0] mem_addr;
        logic [15:0] mem_data;
        logic        vid_we;
        logic [17:0] vid_addr;
        logic [15:0] vid_data;
        logic        port_we;
        logic [2:0]  port_sel;
        logic [15:0] port_data;
        phase_type   phase;
    } exec_state_type;
endpackage

// ===== design/exec_state_reg.sv
// State register for the execution unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module exec_state_reg
    import exec_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire exec_state_type d_nxt,
    output exec_state_type      q_r
);
    always_ff @(posedge clk) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= d_nxt;
        end
    end
endmodule

// ===== design/branch_sysreg_store_exec.sv
// Executes jumps, system-register moves, immediate arithmetic and special stores.
// Assumes register reads arrive decoded and an instruction strobe valid for one cycle.
`timescale 1ns/1ps
module branch_sysreg_store_exec
    import exec_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    input  wire logic        INSTR_VALID,
    input  wire logic [15:0] INSTR,
    input  wire logic [15:0] PC_IN,
    input  wire logic [1:0]  THREAD_ID,
    input  wire logic [15:0] FIRST_SOURCE_DATA,
    input  wire logic [15:0] SECOND_SOURCE_DATA,
    input  wire logic [15:0] DEST_DATA,
    input  wire logic [7:0]  FLAGS_IN,
    input  wire logic [7:0]  SYNC_STATE,
    input  wire logic [3:0]  ACTIVE_THREADS,
    input  wire logic [3:0]  WAITING_THREADS,
    input  wire logic [15:0] IRQ_VECTOR,
    input  wire logic        IRQ_REQ,
    input  wire logic        PORT_ACCEPT,
    output logic [15:0]      PC_OUT,
    output logic             PC_LOAD,
    output logic             EXCEPTION,
    output logic [4:0]       EXC_BITS,
    output logic [15:0]      RD_WDATA,
    output logic [2:0]       RD_WIDX,
    output logic             RD_WE,
    output logic [15:0]      RA_WDATA,
    output logic [2:0]       RA_WIDX,
    output logic             RA_WE,
    output logic [7:0]       FLAGS_OUT,
    output logic             FLAGS_WE,
    output logic [15:0]      RETURN_ADDR,
    output logic [15:0]      FAULT_ADDR,
    output logic [4:0]       CAUSE,
    output logic             ZERO_WRITE_EN,
    output logic             IRQ_MASK,
    output logic             IRQ_ACK,
    output logic             MEM_WE,
    output logic [15:0]      MEM_ADDR,
    output logic [15:0]      MEM_WDATA,
    output logic             VID_WE,
    output logic [17:0]      VID_ADDR,
    output logic [15:0]      VID_WDATA,
    output logic             PORT_WE,
    output logic [2:0]       PORT_SEL,
    output logic [15:0]      PORT_WDATA
);
    exec_state_type s_r;
    exec_state_type s_nxt;
    logic           irq_sync1_r;
    logic           irq_sync2_r;
    logic           ack_r;
    logic [15:0]    irq_vec_r;

    // The request comes from an outside device, so it is synchronised first.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            irq_sync1_r <= 1'b0;
            irq_sync2_r <= 1'b0;
            ack_r       <= 1'b0;
            irq_vec_r   <= 16'h0000;
        end else begin
            irq_sync1_r <= IRQ_REQ;
            irq_sync2_r <= irq_sync1_r;
            ack_r       <= irq_sync2_r & ~s_nxt.irq_mask & ~s_nxt.irq_block;
            // The device may drop its address after the acknowledge, so it is held here.
            if (irq_sync2_r & ~s_nxt.irq_mask & ~s_nxt.irq_block) begin
                irq_vec_r <= IRQ_VECTOR;
            end
        end
    end

    function automatic logic pred_ok(input logic [2:0] sel, input logic [7:0] fl);
        pred_ok = (sel == 3'h0) ? 1'b1 : fl[sel];
    endfunction

    function automatic logic [4:0] target_check(input logic [15:0] tgt);
        logic [4:0] e;
        e = 5'h00;
        if (tgt[0]) begin
            e = e | `EXC_UNALIGNED;
        end
        if (tgt >= `DATA_BASE) begin
            e = e | `EXC_BADADDR;
        end
        target_check = e;
    endfunction

    logic [4:0]  op;
    logic [1:0]  sub;
    logic [2:0]  ra_i;
    logic [2:0]  rb_i;
    logic [2:0]  rd_i;
    logic [15:0] tgt;
    logic [4:0]  chk;
    logic [16:0] sum16;
    logic [8:0]  lo9;
    logic [8:0]  hi9;
    logic [15:0] three_bit_immediate;

    always_comb begin
        op    = INSTR[15:11];
        sub   = INSTR[10:9];
        ra_i  = INSTR[8:6];
        rb_i  = INSTR[5:3];
        rd_i  = INSTR[2:0];
        tgt   = FIRST_SOURCE_DATA;
        chk   = 5'h00;
        sum16 = 17'h00000;
        lo9   = 9'h000;
        hi9   = 9'h000;
        three_bit_immediate  = {13'h0000, rb_i};
        s_nxt = s_r;
        s_nxt.pc_load  = 1'b0;
        s_nxt.exc      = 1'b0;
        s_nxt.exc_bits = 5'h00;
        s_nxt.rd_we    = 1'b0;
        s_nxt.ra_we    = 1'b0;
        s_nxt.flags_we = 1'b0;
        s_nxt.mem_we   = 1'b0;
        s_nxt.vid_we   = 1'b0;
        s_nxt.port_we  = 1'b0;
        s_nxt.irq_block = 1'b0;
        s_nxt.rd_idx   = rd_i;
        s_nxt.ra_idx   = ra_i;
        s_nxt.flags    = FLAGS_IN;
        s_nxt.phase    = ST_IDLE;
        if (ack_r) begin
            s_nxt.irq_mask = 1'b1;
        end
        if (INSTR_VALID) begin
            s_nxt.phase = ST_DONE;
            case (op)
                `OP_JUMP_VIA_REGISTER, `OP_JUMP_LINK_VIA_REGISTER: begin
                    if (op == `OP_JUMP_VIA_REGISTER && sub[0]) begin
                        s_nxt.pc       = s_r.ret_addr;
                        s_nxt.pc_load  = 1'b1;
                        s_nxt.irq_mask = 1'b0;
                    end else begin
                        tgt = FIRST_SOURCE_DATA;
                    end
                end
                `OP_JUMP_PC_RELATIVE, `OP_JUMP_LINK_PC_RELATIVE: begin
                    tgt = PC_IN + {{8{INSTR[10]}}, INSTR[10:3]};
                end
                `OP_GET_A: begin
                    s_nxt.rd_we = 1'b1;
                    case (sub)
                        2'h0: s_nxt.rd_data = {8'h00, FLAGS_IN};
                        2'h1: s_nxt.rd_data = s_r.ret_addr;
                        2'h2: s_nxt.rd_data = s_r.fault_addr;
                        default: begin
                            s_nxt.rd_data = {11'h000, s_r.cause};
                            s_nxt.cause   = 5'h00;
                        end
                    endcase
                end
                `OP_GET_A + 5'h01: begin
                    s_nxt.rd_we = 1'b1;
                    case (sub)
                        2'h0: s_nxt.rd_data = {8'h00, SYNC_STATE};
                        2'h1: s_nxt.rd_data = {12'h000, ACTIVE_THREADS};
                        2'h2: s_nxt.rd_data = {12'h000, WAITING_THREADS};
                        default: s_nxt.rd_data = irq_vec_r;
                    endcase
                end
                `OP_PUT: begin
                    case (sub)
                        2'h0: begin
                            s_nxt.flags    = FIRST_SOURCE_DATA[7:0];
                            s_nxt.flags_we = 1'b1;
                        end
                        2'h1: s_nxt.ret_addr = FIRST_SOURCE_DATA;
                        2'h2: s_nxt.zero_en  = INSTR[3];
                        default: begin
                            s_nxt.irq_mask  = INSTR[3];
                            s_nxt.irq_block = 1'b1;
                        end
                    endcase
                end
                `OP_ADDSUBI: begin
                    s_nxt.rd_we    = 1'b1;
                    s_nxt.flags_we = 1'b1;
                    if (!sub[1]) begin
                        sum16 = {1'b0, FIRST_SOURCE_DATA} + {1'b0, three_bit_immediate};
                        lo9   = {1'b0, FIRST_SOURCE_DATA[7:0]} + {6'h00, rb_i};
                        hi9   = {1'b0, FIRST_SOURCE_DATA[15:8]} + {6'h00, rb_i};
                    end else begin
                        sum16 = {1'b0, FIRST_SOURCE_DATA} - {1'b0, three_bit_immediate};
                        lo9   = {1'b0, FIRST_SOURCE_DATA[7:0]} - {6'h00, rb_i};
                        hi9   = {1'b0, FIRST_SOURCE_DATA[15:8]} - {6'h00, rb_i};
                    end
                    if (sub[0]) begin
                        s_nxt.rd_data = sum16[15:0];
                        s_nxt.flags[`CARRY_FLAG] = sum16[16];
                    end else begin
                        s_nxt.rd_data = {hi9[7:0], lo9[7:0]};
                        s_nxt.flags[`CARRY_FLAG]    = lo9[8];
                        s_nxt.flags[`CARRY_HI_FLAG] = hi9[8];
                    end
                end
                `OP_THREAD: begin
                    s_nxt.rd_we   = 1'b1;
                    s_nxt.rd_data = {14'h0000, THREAD_ID};
                end
                `OP_STORE: begin
                    if (sub == 2'h0) begin
                        chk = target_check(FIRST_SOURCE_DATA);
                        chk[2] = (FIRST_SOURCE_DATA < `DATA_BASE);
                        s_nxt.port_we   = 1'b1;
                        s_nxt.port_sel  = DEST_DATA[2:0];
                        s_nxt.port_data = SECOND_SOURCE_DATA;
                        s_nxt.flags[`CARRY_FLAG] = PORT_ACCEPT;
                        s_nxt.flags_we  = 1'b1;
                        if (chk != 5'h00) begin
                            s_nxt.exc      = 1'b1;
                            s_nxt.exc_bits = chk;
                            s_nxt.cause    = s_r.cause | chk;
                            s_nxt.fault_addr = PC_IN;
                        end else begin
                            s_nxt.mem_we   = 1'b1;
                            s_nxt.mem_addr = FIRST_SOURCE_DATA;
                            s_nxt.mem_data = SECOND_SOURCE_DATA;
                        end
                    end else begin
                        s_nxt.vid_addr = {DEST_DATA[1:0], SECOND_SOURCE_DATA};
                        s_nxt.vid_data = FIRST_SOURCE_DATA;
                        s_nxt.vid_we   = (DEST_DATA != 16'h0000);
                        s_nxt.ra_we    = (sub != 2'h1);
                        s_nxt.ra_data  = (sub == 2'h2) ? FIRST_SOURCE_DATA + 16'h0001
                                                       : FIRST_SOURCE_DATA - 16'h0001;
                    end
                end
                default: begin
                end
            endcase
            if ((op == `OP_JUMP_VIA_REGISTER && !sub[0]) || op == `OP_JUMP_LINK_VIA_REGISTER
                || op == `OP_JUMP_PC_RELATIVE || op == `OP_JUMP_LINK_PC_RELATIVE) begin
                if (pred_ok(rd_i, FLAGS_IN)) begin
                    chk = target_check(tgt);
                    if (chk != 5'h00) begin
                        s_nxt.exc        = 1'b1;
                        s_nxt.exc_bits   = chk;
                        s_nxt.cause      = s_r.cause | chk;
                        s_nxt.fault_addr = PC_IN;
                    end else begin
                        s_nxt.pc      = tgt;
                        s_nxt.pc_load = 1'b1;
                    end
                end
                if (op == `OP_JUMP_LINK_VIA_REGISTER || op == `OP_JUMP_LINK_PC_RELATIVE) begin
                    s_nxt.rd_we   = 1'b1;
                    s_nxt.rd_idx  = `LINK_REG;
                    s_nxt.rd_data = PC_IN + `PC_STEP;
                end
            end
        end
        // Register zero writes on the RD port are dropped unless the enable is set, RA port writes are not; a put that clears the enable still writes zero to it.
        if (s_nxt.rd_we && s_nxt.rd_idx == 3'h0 && !s_nxt.zero_en) begin
            s_nxt.rd_we = 1'b0;
        end
        if (INSTR_VALID && op == `OP_PUT && sub == 2'h2 && !INSTR[3]) begin
            s_nxt.rd_we   = 1'b1;
            s_nxt.rd_idx  = 3'h0;
            s_nxt.rd_data = 16'h0000;
        end
    end

    exec_state_reg u_state (
        .clk   (CLK_SYS),
        .rst   (RESET),
        .d_nxt (s_nxt),
        .q_r   (s_r)
    );

    always_comb begin
        PC_OUT        = s_r.pc;
        PC_LOAD       = s_r.pc_load;
        EXCEPTION     = s_r.exc;
        EXC_BITS      = s_r.exc_bits;
        RD_WDATA      = s_r.rd_data;
        RD_WIDX       = s_r.rd_idx;
        RD_WE         = s_r.rd_we;
        RA_WDATA      = s_r.ra_data;
        RA_WIDX       = s_r.ra_idx;
        RA_WE         = s_r.ra_we;
        FLAGS_OUT     = s_r.flags;
        FLAGS_WE      = s_r.flags_we;
        RETURN_ADDR   = s_r.ret_addr;
        FAULT_ADDR    = s_r.fault_addr;
        CAUSE         = s_r.cause;
        ZERO_WRITE_EN = s_r.zero_en;
        IRQ_MASK      = s_r.irq_mask;
        IRQ_ACK       = ack_r;
        MEM_WE        = s_r.mem_we;
        MEM_ADDR      = s_r.mem_addr;
        MEM_WDATA     = s_r.mem_data;
        VID_WE        = s_r.vid_we;
        VID_ADDR      = s_r.vid_addr;
        VID_WDATA     = s_r.vid_data;
        PORT_WE       = s_r.port_we;
        PORT_SEL      = s_r.port_sel;
        PORT_WDATA    = s_r.port_data;
    end
endmodule

// ===== testbench/exec_monitor.sv
// Concurrent checks on the execution unit, seen only through its top-level ports.
// Assumes the design folder on the include path and the bind at the foot of this file.
`timescale 1ns/1ps
`include "exec_cfg.svh"
module exec_monitor
    import exec_pkg::*;
(
    input wire logic        CLK_SYS,
    input wire logic        RESET,
    input wire logic        INSTR_VALID,
    input wire logic [15:0] INSTR,
    input wire logic [15:0] PC_IN,
    input wire logic [15:0] FIRST_SOURCE_DATA,
    input wire logic [15:0] SECOND_SOURCE_DATA,
    input wire logic [15:0] DEST_DATA,
    input wire logic [7:0]  FLAGS_IN,
    input wire logic [15:0] PC_OUT,
    input wire logic        PC_LOAD,
    input wire logic        EXCEPTION,
    input wire logic [4:0]  EXC_BITS,
    input wire logic [15:0] RD_WDATA,
    input wire logic [2:0]  RD_WIDX,
    input wire logic        RD_WE,
    input wire logic [7:0]  FLAGS_OUT,
    input wire logic        FLAGS_WE,
    input wire logic [15:0] RETURN_ADDR,
    input wire logic [4:0]  CAUSE,
    input wire logic        IRQ_MASK,
    input wire logic        IRQ_ACK,
    input wire logic        VID_WE,
    input wire logic [17:0] VID_ADDR,
    input wire logic [15:0] VID_WDATA
);
    wire [4:0]  op      = INSTR[15:11];
    wire [2:0]  sel     = INSTR[2:0];
    wire        one_bit_immediate    = INSTR[3];
    wire [15:0] src     = FIRST_SOURCE_DATA;
    wire [15:0] rel_tgt = PC_IN + {{8{INSTR[10]}}, INSTR[10:3]};
    wire        cond    = (sel == 3'h0) || FLAGS_IN[sel];
    wire        is_jump = (op >= `OP_JUMP_VIA_REGISTER) && (op <= `OP_JUMP_LINK_PC_RELATIVE) && !(op == `OP_JUMP_VIA_REGISTER && INSTR[9]);

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    // A register jump is decoded first; the target checks then split on its value.
    sequence s_reg_jump;
        INSTR_VALID && op == `OP_JUMP_VIA_REGISTER && !INSTR[9] && cond;
    endsequence
    sequence s_mask_wr;
        INSTR_VALID && op == `OP_PUT && INSTR[10:9] == 2'h3;
    endsequence
    sequence s_video;
        INSTR_VALID && op == `OP_STORE && INSTR[10:9] != 2'h0;
    endsequence

    a_reg_jump_taken: assert property (s_reg_jump ##0 (!src[0] && src < `DATA_BASE)
        |=> PC_LOAD && PC_OUT == $past(src)) else $error("register jump not taken");
    a_jump_skipped: assert property (INSTR_VALID && is_jump && !cond
        |=> !PC_LOAD && !EXCEPTION) else $error("jump taken with clear predicate");
    a_rel_jump: assert property (INSTR_VALID && op == `OP_JUMP_PC_RELATIVE && sel == 3'h0 && !rel_tgt[0]
        && rel_tgt < `DATA_BASE |=> PC_LOAD && PC_OUT == $past(rel_tgt))
        else $error("relative target wrong");
    a_link_write: assert property (INSTR_VALID && op == `OP_JUMP_LINK_VIA_REGISTER && sel == 3'h0 && !src[0]
        && src < `DATA_BASE |=> RD_WE && RD_WIDX == `LINK_REG
        && RD_WDATA == $past(PC_IN) + `PC_STEP) else $error("link value wrong");
    a_misalign_exc: assert property (s_reg_jump ##0 src[0] |=> EXCEPTION && !PC_LOAD
        && (EXC_BITS & `EXC_UNALIGNED) != 5'h00) else $error("misaligned jump accepted");
    a_badaddr_exc: assert property (s_reg_jump ##0 (!src[0] && src >= `DATA_BASE)
        |=> EXCEPTION && !PC_LOAD && (EXC_BITS & `EXC_BADADDR) != 5'h00)
        else $error("data region jump accepted");
    a_flag_read: assert property (INSTR_VALID && op == `OP_GET_A && INSTR[10:9] == 2'h0
        && sel != 3'h0 |=> RD_WE && RD_WDATA == {8'h00, $past(FLAGS_IN)})
        else $error("flag read wrong");
    a_cause_clear: assert property (INSTR_VALID && op == `OP_GET_A && INSTR[10:9] == 2'h3
        |=> CAUSE == 5'h00) else $error("cause not cleared");
    a_flag_write: assert property (INSTR_VALID && op == `OP_PUT && INSTR[10:9] == 2'h0
        |=> FLAGS_WE && FLAGS_OUT == $past(src[7:0])) else $error("flag write wrong");
    a_mask_write: assert property (s_mask_wr |=> IRQ_MASK == $past(one_bit_immediate) && !$rose(IRQ_ACK))
        else $error("mask write wrong");
    a_irq_return: assert property (INSTR_VALID && op == `OP_JUMP_VIA_REGISTER && INSTR[9] && IRQ_MASK
        |=> PC_LOAD && PC_OUT == $past(RETURN_ADDR) && !IRQ_MASK)
        else $error("interrupt return wrong");
    a_video_store: assert property (s_video ##0 DEST_DATA != 16'h0000 |=> VID_WE
        && VID_ADDR == {$past(DEST_DATA[1:0]), $past(SECOND_SOURCE_DATA)}
        && VID_WDATA == $past(src)) else $error("video store wrong");
    a_video_cancel: assert property (s_video ##0 DEST_DATA == 16'h0000 |=> !VID_WE)
        else $error("video store not cancelled");
endmodule

bind branch_sysreg_store_exec exec_monitor i_mon (.CLK_SYS, .RESET, .INSTR_VALID, .INSTR,
    .PC_IN, .FIRST_SOURCE_DATA, .SECOND_SOURCE_DATA, .DEST_DATA, .FLAGS_IN, .PC_OUT, .PC_LOAD,
    .EXCEPTION, .EXC_BITS, .RD_WDATA, .RD_WIDX, .RD_WE, .FLAGS_OUT, .FLAGS_WE, .RETURN_ADDR,
    .CAUSE, .IRQ_MASK, .IRQ_ACK, .VID_WE, .VID_ADDR, .VID_WDATA);

// ===== testbench/tb_top.sv
// Directed testbench for the execution unit: one task per scenario.
// Assumes the design folder on the include path; inputs change 2 ns after each rising edge.
`timescale 1ns/1ps
`include "exec_cfg.svh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, a); end end
module tb_top;
    import exec_pkg::*;
    logic        CLK_SYS, RESET, INSTR_VALID, IRQ_REQ, PORT_ACCEPT;
    logic [15:0] INSTR, PC_IN, FIRST_SOURCE_DATA, SECOND_SOURCE_DATA, DEST_DATA, IRQ_VECTOR;
    logic [15:0] PC_OUT, RD_WDATA, RA_WDATA, RETURN_ADDR, FAULT_ADDR, MEM_ADDR, MEM_WDATA;
    logic [15:0] VID_WDATA, PORT_WDATA;
    logic [7:0]  FLAGS_IN, SYNC_STATE, FLAGS_OUT;
    logic [3:0]  ACTIVE_THREADS, WAITING_THREADS;
    logic [1:0]  THREAD_ID;
    logic [4:0]  EXC_BITS, CAUSE;
    logic [2:0]  RD_WIDX, RA_WIDX, PORT_SEL;
    logic [17:0] VID_ADDR;
    logic        PC_LOAD, EXCEPTION, RD_WE, RA_WE, FLAGS_WE, ZERO_WRITE_EN, IRQ_MASK, IRQ_ACK;
    logic        MEM_WE, VID_WE, PORT_WE;
    int          errors, checks_done;

    branch_sysreg_store_exec i_dut (.CLK_SYS, .RESET, .INSTR_VALID, .INSTR, .PC_IN, .THREAD_ID,
        .FIRST_SOURCE_DATA, .SECOND_SOURCE_DATA, .DEST_DATA, .FLAGS_IN, .SYNC_STATE,
        .ACTIVE_THREADS, .WAITING_THREADS, .IRQ_VECTOR, .IRQ_REQ, .PORT_ACCEPT, .PC_OUT,
        .PC_LOAD, .EXCEPTION, .EXC_BITS, .RD_WDATA, .RD_WIDX, .RD_WE, .RA_WDATA, .RA_WIDX,
        .RA_WE, .FLAGS_OUT, .FLAGS_WE, .RETURN_ADDR, .FAULT_ADDR, .CAUSE, .ZERO_WRITE_EN,
        .IRQ_MASK, .IRQ_ACK, .MEM_WE, .MEM_ADDR, .MEM_WDATA, .VID_WE, .VID_ADDR, .VID_WDATA,
        .PORT_WE, .PORT_SEL, .PORT_WDATA);

    initial begin
        CLK_SYS = 1'b0;
        forever #25 CLK_SYS = ~CLK_SYS;
    end

    function automatic logic [15:0] ins(logic [4:0] op, logic [1:0] sb, logic [2:0] a,
                                        logic [2:0] b, logic [2:0] d);
        return {op, sb, a, b, d};
    endfunction

    // Every effect is registered, so results are read 2 ns after the taking edge.
    task automatic issue(input logic [15:0] i);
        INSTR_VALID = 1'b1;
        INSTR = i;
        @(posedge CLK_SYS);
        #2;
        INSTR_VALID = 1'b0;
    endtask

    task automatic src(input logic [15:0] a, input logic [15:0] b, input logic [15:0] d);
        FIRST_SOURCE_DATA = a;
        SECOND_SOURCE_DATA = b;
        DEST_DATA = d;
    endtask

    task automatic rd_chk(input logic [15:0] i, input logic [15:0] e);
        issue(i);
        `CHK("rd_we", 1'b1, RD_WE)
        `CHK("rd_wdata", e, RD_WDATA)
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic t_jumps;
        PC_IN = 16'h0100;
        FLAGS_IN = 8'h08;
        src(16'h0200, 16'h0000, 16'h0000);
        issue(ins(`OP_JUMP_VIA_REGISTER, 2'h0, 3'h1, 3'h0, 3'h0));
        `CHK("pc_out", 16'h0200, PC_OUT)
        issue(ins(`OP_JUMP_VIA_REGISTER, 2'h0, 3'h1, 3'h0, 3'h3));
        `CHK("pc_load", 1'b1, PC_LOAD)
        issue(ins(`OP_JUMP_VIA_REGISTER, 2'h0, 3'h1, 3'h0, 3'h2));
        `CHK("pc_load", 1'b0, PC_LOAD)
        rd_chk(ins(`OP_JUMP_LINK_VIA_REGISTER, 2'h0, 3'h1, 3'h0, 3'h0), 16'h0102);
        `CHK("rd_widx", 3'h7, RD_WIDX)
        issue(ins(`OP_JUMP_PC_RELATIVE, 2'h3, 3'h6, 3'h0, 3'h0));
        `CHK("pc_out", 16'h00F0, PC_OUT)
        rd_chk(ins(`OP_JUMP_LINK_PC_RELATIVE, 2'h0, 3'h0, 3'h4, 3'h3), 16'h0102);
        `CHK("pc_out", 16'h0104, PC_OUT)
        src(16'h0201, 16'h0000, 16'h0000);
        issue(ins(`OP_JUMP_VIA_REGISTER, 2'h0, 3'h1, 3'h0, 3'h0));
        `CHK("exc_bits", 5'h02, EXC_BITS)
        `CHK("pc_load", 1'b0, PC_LOAD)
        src(16'h9000, 16'h0000, 16'h0000);
        issue(ins(`OP_JUMP_VIA_REGISTER, 2'h0, 3'h1, 3'h0, 3'h0));
        `CHK("exc_bits", 5'h04, EXC_BITS)
        rd_chk(ins(`OP_GET_A, 2'h3, 3'h0, 3'h0, 3'h1), 16'h0006);
        rd_chk(ins(`OP_GET_A, 2'h3, 3'h0, 3'h0, 3'h1), 16'h0000);
        rd_chk(ins(`OP_GET_A, 2'h2, 3'h0, 3'h0, 3'h1), 16'h0100);
        $display("test jumps done");
    endtask

    task automatic t_sysregs;
        FLAGS_IN = 8'hA5;
        rd_chk(ins(`OP_GET_A, 2'h0, 3'h0, 3'h0, 3'h2), 16'h00A5);
        rd_chk(ins(`OP_GET_B, 2'h0, 3'h0, 3'h0, 3'h2), 16'h003C);
        rd_chk(ins(`OP_GET_B, 2'h1, 3'h0, 3'h0, 3'h2), 16'h0009);
        rd_chk(ins(`OP_GET_B, 2'h2, 3'h0, 3'h0, 3'h2), 16'h0006);
        rd_chk(ins(`OP_THREAD, 2'h0, 3'h0, 3'h0, 3'h2), 16'h0002);
        src(16'h12C3, 16'h0000, 16'h0000);
        issue(ins(`OP_PUT, 2'h0, 3'h1, 3'h0, 3'h0));
        `CHK("flags_out", 8'hC3, FLAGS_OUT)
        issue(ins(`OP_PUT, 2'h1, 3'h1, 3'h0, 3'h0));
        `CHK("return_addr", 16'h12C3, RETURN_ADDR)
        rd_chk(ins(`OP_GET_A, 2'h1, 3'h0, 3'h0, 3'h2), 16'h12C3);
        issue(ins(`OP_GET_A, 2'h0, 3'h0, 3'h0, 3'h0));
        `CHK("rd_we", 1'b0, RD_WE)
        issue(ins(`OP_PUT, 2'h2, 3'h0, 3'h1, 3'h0));
        `CHK("zero_en", 1'b1, ZERO_WRITE_EN)
        rd_chk(ins(`OP_GET_A, 2'h0, 3'h0, 3'h0, 3'h0), 16'h00A5);
        issue(ins(`OP_PUT, 2'h2, 3'h0, 3'h0, 3'h0));
        `CHK("zero_en", 1'b0, ZERO_WRITE_EN)
        $display("test sysregs done");
    endtask

    task automatic t_irq;
        int n;
        issue(ins(`OP_PUT, 2'h3, 3'h0, 3'h1, 3'h0));
        `CHK("irq_mask", 1'b1, IRQ_MASK)
        IRQ_VECTOR = 16'h4440;
        IRQ_REQ = 1'b1;
        n = 0;
        repeat (6) begin
            @(posedge CLK_SYS);
            #2;
            n += IRQ_ACK;
        end
        `CHK("acks_masked", 0, n)
        issue(ins(`OP_PUT, 2'h3, 3'h0, 3'h0, 3'h0));
        `CHK("irq_ack", 1'b0, IRQ_ACK)
        `CHK("irq_mask", 1'b0, IRQ_MASK)
        n = 0;
        while (IRQ_ACK !== 1'b1) begin
            if (++n > 6) begin
                errors++;
                $display("mismatch irq_ack expected 1 seen 0");
                summarize();
            end
            @(posedge CLK_SYS);
            #2;
        end
        IRQ_REQ = 1'b0;
        IRQ_VECTOR = 16'h0000;
        @(posedge CLK_SYS);
        #2;
        rd_chk(ins(`OP_GET_B, 2'h3, 3'h0, 3'h0, 3'h2), 16'h4440);
        src(16'h0300, 16'h0000, 16'h0000);
        issue(ins(`OP_PUT, 2'h1, 3'h1, 3'h0, 3'h0));
        issue(ins(`OP_JUMP_VIA_REGISTER, 2'h1, 3'h0, 3'h0, 3'h0));
        `CHK("pc_out", 16'h0300, PC_OUT)
        `CHK("irq_mask", 1'b0, IRQ_MASK)
        $display("test irq done");
    endtask

    // Overflow raises a lane flag; the other flag bits pass through from the input.
    task automatic ar(input logic [1:0] sb, input logic [15:0] a, input logic [2:0] imm,
                      input logic [15:0] res, input logic [7:0] fl);
        src(a, 16'h0000, 16'h0000);
        rd_chk(ins(`OP_ADDSUBI, sb, 3'h1, imm, 3'h4), res);
        `CHK("flags_out", fl, FLAGS_OUT)
    endtask

    task automatic t_arith;
        FLAGS_IN = 8'h41;
        ar(2'h1, 16'hFFFF, 3'h1, 16'h0000, 8'h41);
        ar(2'h0, 16'h80FF, 3'h2, 16'h8201, 8'h41);
        ar(2'h3, 16'h0001, 3'h3, 16'hFFFE, 8'h41);
        ar(2'h2, 16'h0105, 3'h3, 16'hFE02, 8'h81);
        ar(2'h1, 16'h0010, 3'h7, 16'h0017, 8'h01);
        $display("test arith done");
    endtask

    task automatic t_store;
        FLAGS_IN = 8'h00;
        PORT_ACCEPT = 1'b1;
        src(16'h8010, 16'h5A5A, 16'h0005);
        issue(ins(`OP_STORE, 2'h0, 3'h1, 3'h2, 3'h3));
        `CHK("mem", {1'b1, 16'h8010, 16'h5A5A}, {MEM_WE, MEM_ADDR, MEM_WDATA})
        `CHK("port", {1'b1, 3'h5, 16'h5A5A}, {PORT_WE, PORT_SEL, PORT_WDATA})
        `CHK("flags_out", 8'h40, FLAGS_OUT)
        PORT_ACCEPT = 1'b0;
        src(16'h0010, 16'h1234, 16'h0002);
        issue(ins(`OP_STORE, 2'h0, 3'h1, 3'h2, 3'h3));
        `CHK("mem_we", 1'b0, MEM_WE)
        `CHK("exc_port", {1'b1, 5'h04, 1'b1}, {EXCEPTION, EXC_BITS, PORT_WE})
        `CHK("flags_out", 8'h00, FLAGS_OUT)
        src(16'hABCD, 16'h1357, 16'h0002);
        issue(ins(`OP_STORE, 2'h1, 3'h1, 3'h2, 3'h3));
        `CHK("vid", {1'b1, 18'h21357, 16'hABCD}, {VID_WE, VID_ADDR, VID_WDATA})
        `CHK("exception", 1'b0, EXCEPTION)
        src(16'hABCD, 16'h1357, 16'h0000);
        issue(ins(`OP_STORE, 2'h1, 3'h1, 3'h2, 3'h3));
        `CHK("vid_we", 1'b0, VID_WE)
        src(16'hABCD, 16'h1357, 16'h0001);
        issue(ins(`OP_STORE, 2'h2, 3'h1, 3'h2, 3'h3));
        `CHK("ra_inc", {1'b1, 3'h1, 16'hABCE}, {RA_WE, RA_WIDX, RA_WDATA})
        issue(ins(`OP_STORE, 2'h3, 3'h1, 3'h2, 3'h3));
        `CHK("ra_dec", {1'b1, 3'h1, 16'hABCC}, {RA_WE, RA_WIDX, RA_WDATA})
        $display("test store done");
    endtask

    initial begin
        errors = 0;
        checks_done = 0;
        {RESET, INSTR_VALID, IRQ_REQ, PORT_ACCEPT, INSTR, PC_IN, IRQ_VECTOR} = '0;
        {FIRST_SOURCE_DATA, SECOND_SOURCE_DATA, DEST_DATA, FLAGS_IN} = '0;
        {SYNC_STATE, ACTIVE_THREADS, WAITING_THREADS, THREAD_ID} = {8'h3C, 4'h9, 4'h6, 2'h2};
        RESET = 1'b1;
        repeat (6) @(posedge CLK_SYS);
        #2;
        RESET = 1'b0;
        t_jumps();
        t_sysregs();
        t_irq();
        t_arith();
        t_store();
        summarize();
    end
endmodule
